/* File: instrument_bus_regs.svh */
// register offsets, reset values, bus command codes and timing counts
`ifndef INSTRUMENT_BUS_REGS_SVH
`define INSTRUMENT_BUS_REGS_SVH
`define CTRL_OFS 5'h00
`define STAT_OFS 5'h04
`define SRE_OFS 5'h08
`define STB_OFS 5'h0c
`define RX_OFS 5'h10
`define TX_OFS 5'h14
`define TXCMD_OFS 5'h18
`define ADDR_DEF 5'h0c
`define ADDR_MIN 5'h01
`define ADDR_MAX 5'h1e
`define MSG_MAX 64
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_UNL 7'h3f
`define CMD_UNT 7'h5f
`define CHR_CR 8'h0d
`define CHR_LF 8'h0a
`define CHR_SEMI 8'h3b
`define RQS_BIT 6
`define CLK_NS 100
`define SETTLE_NS 500
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* File: instrument_bus_pkg.sv */
// types shared by the instrument bus port
package instrument_bus_pkg;
    typedef enum logic [1:0] {TERM_CRLF, TERM_LFCR, TERM_LF, TERM_EOI} term_sel_t;
    typedef enum logic [1:0] {AH_IDLE, AH_WAIT_DAV, AH_WAIT_REL} ah_state_t;
    typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_WAIT_RFD, SH_WAIT_DAC} sh_state_t;
    typedef enum logic [1:0] {PH_DATA, PH_TERM1, PH_TERM2} tx_phase_t;
endpackage

/* File: instrument_bus_talker_listener.sv */
// device-side talker/listener port of the instrument bus
`include "instrument_bus_regs.svh"

module instrument_bus_talker_listener
    import instrument_bus_pkg::*;
#(
    parameter int DEPTH = `MSG_MAX
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [4:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [7:0] dio_i,
    input wire logic atn_n_i,
    input wire logic ren_n_i,
    input wire logic ifc_n_i,
    input wire logic eoi_n_i,
    input wire logic dav_n_i,
    input wire logic nrfd_n_i,
    input wire logic ndac_n_i,
    output logic [7:0] dio_o,
    output logic dio_oe_o,
    output logic dav_oe_o,
    output logic eoi_oe_o,
    output logic nrfd_oe_o,
    output logic ndac_oe_o,
    output logic srq_oe_o,
    output logic remote_o,
    output logic lockout_o,
    output logic dev_clear_o
);
    localparam int PW = $clog2(DEPTH) + 1;
    localparam logic [2:0] SETTLE_CYC = 3'(`SETTLE_CYC);

    logic [4:0] addr_reg;
    term_sel_t term_reg;
    logic talk_only_reg, sel_reg;
    logic [7:0] sre_reg, stb_reg;
    logic listen_reg, talk_reg, spoll_reg;
    logic remote_reg, lockout_reg, ren_prev_reg;
    ah_state_t ah_state;
    sh_state_t sh_state;
    logic [2:0] settle_reg;
    logic [7:0] rx_byte_reg, prev_reg;
    logic rx_sep_reg, rx_eom_reg, rx_valid_reg, msg_open_reg;
    logic [7:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, len_reg;
    logic resp_ready_reg, tx_poll_reg;
    tx_phase_t phase_reg;
    logic [7:0] dio_reg, sent_reg;
    logic dio_oe_reg, dav_oe_reg, eoi_oe_reg, nrfd_oe_reg, ndac_oe_reg, srq_oe_reg;
    logic dev_clear_reg;
    logic [31:0] rdata_reg;

    // combinational decode of the bus side
    logic [6:0] cmd;
    logic active, ready, take, cmd_take, data_take, abort;
    logic is_mla, is_mta, other_ta, clear_evt, new_msg, term_hit;
    logic talker_act, rqs, src_go, src_stop, byte_done, last_byte;
    logic [7:0] next_byte;
    logic next_eoi;

    assign cmd = dio_i[6:0];
    assign abort = !ifc_n_i;
    assign active = sel_reg && (!atn_n_i || listen_reg);
    // commands are always taken; data waits for software to empty the holding byte
    assign ready = !atn_n_i || !rx_valid_reg;
    assign take = ah_state == AH_WAIT_DAV && ready && !dav_n_i && !abort;
    assign cmd_take = take && !atn_n_i;
    assign data_take = take && atn_n_i;
    assign is_mla = cmd == {2'b01, addr_reg};
    assign is_mta = cmd == {2'b10, addr_reg};
    assign other_ta = cmd[6:5] == 2'b10 && !is_mta && cmd != `CMD_UNT;
    // selective clear only counts while addressed to listen
    assign clear_evt = cmd_take && (cmd == `CMD_DCL || (cmd == `CMD_SDC && listen_reg));
    assign new_msg = data_take && !msg_open_reg;
    assign talker_act = talk_reg || talk_only_reg;
    assign rqs = sre_reg[`RQS_BIT] && |(stb_reg & sre_reg & 8'hbf);

    // a message ends only on the full terminator sequence
    always_comb begin
        case (term_reg)
            TERM_CRLF: term_hit = dio_i == `CHR_LF && prev_reg == `CHR_CR;
            TERM_LFCR: term_hit = dio_i == `CHR_CR && prev_reg == `CHR_LF;
            TERM_LF: term_hit = dio_i == `CHR_LF;
            TERM_EOI: term_hit = !eoi_n_i;
            default: term_hit = 1'b0;
        endcase
    end

    // control and service request enable registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            addr_reg <= `ADDR_DEF;
            term_reg <= TERM_CRLF;
            talk_only_reg <= 1'b0;
            sel_reg <= 1'b1;
            sre_reg <= 8'h00;
        end else if (wr_i && addr_i == `CTRL_OFS) begin
            // out-of-range addresses are ignored, the old one stays
            if (wdata_i[4:0] >= `ADDR_MIN && wdata_i[4:0] <= `ADDR_MAX) begin
                addr_reg <= wdata_i[4:0];
            end
            term_reg <= term_sel_t'(wdata_i[6:5]);
            talk_only_reg <= wdata_i[7];
            sel_reg <= wdata_i[8];
        end else if (wr_i && addr_i == `SRE_OFS) begin
            sre_reg <= wdata_i[7:0];
        end
    end

    // status bits: software sets, a finished poll clears what it reported; set wins
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            stb_reg <= 8'h00;
        end else begin
            stb_reg <= (stb_reg & ~((byte_done && tx_poll_reg) ? sent_reg : 8'h00))
                | ((wr_i && addr_i == `STB_OFS) ? (wdata_i[7:0] & 8'hbf) : 8'h00);
        end
    end

    // addressing; parallel poll and trigger commands fall through untouched
    always_ff @(posedge mclk_i) begin
        if (srst_i || !sel_reg || abort) begin
            listen_reg <= 1'b0;
            talk_reg <= 1'b0;
            spoll_reg <= 1'b0;
        end else if (cmd_take) begin
            if (is_mla) begin
                listen_reg <= 1'b1;
                talk_reg <= 1'b0;
            end else if (is_mta) begin
                talk_reg <= 1'b1;
                listen_reg <= 1'b0;
            end else if (cmd == `CMD_UNL) begin
                listen_reg <= 1'b0;
            end else if (cmd == `CMD_UNT || other_ta) begin
                talk_reg <= 1'b0;
            end else if (cmd == `CMD_SPE) begin
                spoll_reg <= 1'b1;
            end else if (cmd == `CMD_SPD) begin
                spoll_reg <= 1'b0;
            end
        end
    end

    // remote and lockout follow REN; dropping REN returns everything to local
    always_ff @(posedge mclk_i) begin
        if (srst_i || ren_n_i || !sel_reg) begin
            remote_reg <= 1'b0;
            lockout_reg <= 1'b0;
            ren_prev_reg <= 1'b0;
        end else begin
            ren_prev_reg <= 1'b1;
            if (!ren_prev_reg || (cmd_take && is_mla)) begin
                remote_reg <= 1'b1;
            end else if (cmd_take && cmd == `CMD_GTL && listen_reg) begin
                remote_reg <= 1'b0;
            end
            if (cmd_take && cmd == `CMD_LLO) begin
                lockout_reg <= 1'b1;
            end
        end
    end

    // acceptor handshake: take on DAV, release NDAC, wait for DAV to go away
    always_ff @(posedge mclk_i) begin
        if (srst_i || abort || !active) begin
            ah_state <= AH_IDLE;
        end else begin
            case (ah_state)
                AH_IDLE: ah_state <= AH_WAIT_DAV;
                AH_WAIT_DAV: ah_state <= take ? AH_WAIT_REL : AH_WAIT_DAV;
                AH_WAIT_REL: ah_state <= dav_n_i ? AH_WAIT_DAV : AH_WAIT_REL;
                default: ah_state <= AH_IDLE;
            endcase
        end
    end

    // holding lines from flops costs one cycle of lag, which the handshake tolerates
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            nrfd_oe_reg <= 1'b0;
            ndac_oe_reg <= 1'b0;
        end else begin
            nrfd_oe_reg <= active && !abort && !(ah_state == AH_WAIT_DAV && ready && !take);
            ndac_oe_reg <= active && !abort && ah_state != AH_WAIT_REL && !take;
        end
    end

    // received character holding byte with separator and end flags
    always_ff @(posedge mclk_i) begin
        if (srst_i || clear_evt) begin
            rx_valid_reg <= 1'b0;
            msg_open_reg <= 1'b0;
            prev_reg <= 8'h00;
            rx_byte_reg <= 8'h00;
            rx_sep_reg <= 1'b0;
            rx_eom_reg <= 1'b0;
        end else if (data_take) begin
            rx_byte_reg <= dio_i;
            rx_valid_reg <= 1'b1;
            rx_sep_reg <= dio_i == `CHR_SEMI;
            rx_eom_reg <= term_hit;
            prev_reg <= dio_i;
            msg_open_reg <= !term_hit;
        end else if (rd_i && addr_i == `RX_OFS) begin
            rx_valid_reg <= 1'b0;
        end
    end

    // response store; written by software after it parses a query
    always_ff @(posedge mclk_i) begin
        if (wr_i && addr_i == `TX_OFS && wr_ptr < PW'(DEPTH)) begin
            mem[wr_ptr[PW-2:0]] <= wdata_i[7:0];
        end
    end

    // a new message or a device clear (DCL, or SDC while listening) throws the old answer away; IFC does not
    always_ff @(posedge mclk_i) begin
        if (srst_i || clear_evt || new_msg) begin
            wr_ptr <= '0;
            resp_ready_reg <= 1'b0;
            rd_ptr <= '0;
            len_reg <= '0;
            phase_reg <= PH_DATA;
        end else if (wr_i && addr_i == `TXCMD_OFS && wdata_i[1]) begin
            wr_ptr <= '0;
            resp_ready_reg <= 1'b0;
        end else if (wr_i && addr_i == `TXCMD_OFS && wdata_i[0]) begin
            // an empty answer has nothing to carry under EOI
            resp_ready_reg <= wr_ptr != '0 || term_reg != TERM_EOI;
            len_reg <= wr_ptr;
            rd_ptr <= '0;
            phase_reg <= (wr_ptr == '0) ? PH_TERM1 : PH_DATA;
        end else if (wr_i && addr_i == `TX_OFS && wr_ptr < PW'(DEPTH)) begin
            wr_ptr <= wr_ptr + 1'b1;
        end else if (byte_done && !tx_poll_reg) begin
            if (last_byte) begin
                resp_ready_reg <= 1'b0;
                wr_ptr <= '0;
            end else if (phase_reg == PH_DATA && rd_ptr == len_reg - 1'b1) begin
                phase_reg <= PH_TERM1;
            end else if (phase_reg == PH_DATA) begin
                rd_ptr <= rd_ptr + 1'b1;
            end else begin
                phase_reg <= PH_TERM2;
            end
        end
    end

    // next byte to source: poll status byte, answer text, then terminator
    always_comb begin
        next_eoi = 1'b0;
        last_byte = 1'b0;
        next_byte = mem[rd_ptr[PW-2:0]];
        if (spoll_reg) begin
            next_byte = {stb_reg[7], rqs, stb_reg[5:0]};
        end else begin
            case (phase_reg)
                PH_DATA: begin
                    last_byte = term_reg == TERM_EOI && rd_ptr == len_reg - 1'b1;
                    next_eoi = last_byte;
                end
                PH_TERM1: begin
                    next_byte = (term_reg == TERM_CRLF) ? `CHR_CR : `CHR_LF;
                    last_byte = term_reg == TERM_LF;
                end
                PH_TERM2: begin
                    next_byte = (term_reg == TERM_CRLF) ? `CHR_LF : `CHR_CR;
                    last_byte = 1'b1;
                end
                default: last_byte = 1'b1;
            endcase
        end
    end

    // source only while addressed to talk or in talk-only mode, and ATN is false; never as controller
    assign src_go = talker_act && (spoll_reg || resp_ready_reg);
    assign src_stop = srst_i || !sel_reg || abort || !atn_n_i || !talker_act;
    assign byte_done = sh_state == SH_WAIT_DAC && ndac_n_i && !src_stop;

    // source handshake with a data settling delay before DAV
    always_ff @(posedge mclk_i) begin
        if (src_stop) begin
            sh_state <= SH_IDLE;
            dio_oe_reg <= 1'b0;
            dav_oe_reg <= 1'b0;
            eoi_oe_reg <= 1'b0;
            settle_reg <= 3'h0;
            tx_poll_reg <= 1'b0;
        end else begin
            case (sh_state)
                SH_IDLE: begin
                    dav_oe_reg <= 1'b0;
                    eoi_oe_reg <= 1'b0;
                    dio_oe_reg <= 1'b0;
                    if (src_go) begin
                        dio_oe_reg <= 1'b1;
                        eoi_oe_reg <= next_eoi;
                        tx_poll_reg <= spoll_reg;
                        settle_reg <= SETTLE_CYC - 3'h1;
                        sh_state <= SH_SETTLE;
                    end
                end
                SH_SETTLE: begin
                    settle_reg <= settle_reg - 3'h1;
                    if (settle_reg == 3'h0) begin
                        sh_state <= SH_WAIT_RFD;
                    end
                end
                SH_WAIT_RFD: begin
                    if (nrfd_n_i) begin
                        dav_oe_reg <= 1'b1;
                        sh_state <= SH_WAIT_DAC;
                    end
                end
                SH_WAIT_DAC: begin
                    if (ndac_n_i) begin
                        dav_oe_reg <= 1'b0;
                        eoi_oe_reg <= 1'b0;
                        sh_state <= SH_IDLE;
                    end
                end
                default: sh_state <= SH_IDLE;
            endcase
        end
    end

    // data lines latched with the load so they stay stable under DAV
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dio_reg <= 8'h00;
            sent_reg <= 8'h00;
        end else if (sh_state == SH_IDLE && src_go && !src_stop) begin
            dio_reg <= next_byte;
            sent_reg <= next_byte;
        end
    end

    // service request line and clear pulse
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            srq_oe_reg <= 1'b0;
            dev_clear_reg <= 1'b0;
        end else begin
            srq_oe_reg <= sel_reg && rqs;
            dev_clear_reg <= clear_evt;
        end
    end

    // register reads: data only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (srst_i || !rd_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            case (addr_i)
                `CTRL_OFS: rdata_reg <= {23'h0, sel_reg, talk_only_reg, term_reg, addr_reg};
                `STAT_OFS: rdata_reg <= {24'h0, srq_oe_reg, resp_ready_reg, rx_valid_reg,
                    spoll_reg, listen_reg, talk_reg, lockout_reg, remote_reg};
                `SRE_OFS: rdata_reg <= {24'h0, sre_reg};
                `STB_OFS: rdata_reg <= {24'h0, stb_reg[7], rqs, stb_reg[5:0]};
                `RX_OFS: rdata_reg <= {21'h0, rx_valid_reg, rx_eom_reg, rx_sep_reg, rx_byte_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign rdata_o = rdata_reg;
    assign dio_o = dio_reg;
    assign dio_oe_o = dio_oe_reg;
    assign dav_oe_o = dav_oe_reg;
    assign eoi_oe_o = eoi_oe_reg;
    assign nrfd_oe_o = nrfd_oe_reg;
    assign ndac_oe_o = ndac_oe_reg;
    assign srq_oe_o = srq_oe_reg;
    assign remote_o = remote_reg;
    assign lockout_o = lockout_reg;
    assign dev_clear_o = dev_clear_reg;

    property p_addr_range;
        @(posedge mclk_i) disable iff (srst_i) addr_reg >= `ADDR_MIN && addr_reg <= `ADDR_MAX;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("bus address out of range");

    property p_listen_drops_talk;
        @(posedge mclk_i) disable iff (srst_i) cmd_take && is_mla && !abort |=> listen_reg && !talk_reg;
    endproperty
    a_listen_drops_talk: assert property (p_listen_drops_talk) else $error("talker kept");

    property p_talk_drops_listen;
        @(posedge mclk_i) disable iff (srst_i) cmd_take && is_mta && !abort |=> talk_reg && !listen_reg;
    endproperty
    a_talk_drops_listen: assert property (p_talk_drops_listen) else $error("listener kept");

    property p_quiet_under_atn;
        @(posedge mclk_i) disable iff (srst_i) !atn_n_i |=> !dav_oe_reg && !dio_oe_reg;
    endproperty
    a_quiet_under_atn: assert property (p_quiet_under_atn) else $error("drove bus under ATN");

    property p_ren_remote;
        @(posedge mclk_i) disable iff (srst_i) sel_reg && $fell(ren_n_i) ##1 !ren_n_i && sel_reg |-> remote_reg;
    endproperty
    a_ren_remote: assert property (p_ren_remote) else $error("REN did not give remote");

    property p_ifc_abort;
        @(posedge mclk_i) disable iff (srst_i) !ifc_n_i |=> !talk_reg && !listen_reg && sh_state == SH_IDLE;
    endproperty
    a_ifc_abort: assert property (p_ifc_abort) else $error("IFC did not abort");

    property p_srq_enable;
        @(posedge mclk_i) disable iff (srst_i) srq_oe_reg |-> $past(sre_reg[`RQS_BIT]);
    endproperty
    a_srq_enable: assert property (p_srq_enable) else $error("SRQ without enable");

    property p_llo;
        @(posedge mclk_i) disable iff (srst_i)
            cmd_take && cmd == `CMD_LLO && !ren_n_i && sel_reg ##1 !ren_n_i && sel_reg |-> lockout_reg;
    endproperty
    a_llo: assert property (p_llo) else $error("LLO not taken");

    property p_dcl;
        @(posedge mclk_i) disable iff (srst_i)
            cmd_take && cmd == `CMD_DCL |=> !rx_valid_reg && !resp_ready_reg && dev_clear_reg ##1 !dev_clear_reg;
    endproperty
    a_dcl: assert property (p_dcl) else $error("DCL did not clear");

    property p_sdc_unaddressed;
        @(posedge mclk_i) disable iff (srst_i)
            cmd_take && cmd == `CMD_SDC && !listen_reg |=> !dev_clear_reg;
    endproperty
    a_sdc_unaddressed: assert property (p_sdc_unaddressed) else $error("SDC cleared unaddressed");

    property p_gtl;
        @(posedge mclk_i) disable iff (srst_i)
            cmd_take && cmd == `CMD_GTL && listen_reg && !abort |=> !remote_reg;
    endproperty
    a_gtl: assert property (p_gtl) else $error("GTL kept remote");

    property p_talk_only_tx;
        @(posedge mclk_i) disable iff (srst_i) $rose(dav_oe_reg) |-> $past(talker_act, 2);
    endproperty
    a_talk_only_tx: assert property (p_talk_only_tx) else $error("sourced while not talker");

    property p_single_if;
        @(posedge mclk_i) disable iff (srst_i) !sel_reg ##1 !sel_reg |-> !nrfd_oe_reg && !ndac_oe_reg && !srq_oe_reg;
    endproperty
    a_single_if: assert property (p_single_if) else $error("bus used while deselected");
endmodule

/* File: host_ctrl_model.sv */
// behavioural host controller on the far side of the instrument bus port
module host_ctrl_model (
    input wire logic mclk_i,
    input wire logic [7:0] dio_o,
    input wire logic dio_oe_o,
    input wire logic dav_oe_o,
    input wire logic eoi_oe_o,
    input wire logic nrfd_oe_o,
    input wire logic ndac_oe_o,
    output logic [7:0] dio_i,
    output logic atn_n_i,
    output logic eoi_n_i,
    output logic dav_n_i,
    output logic nrfd_n_i,
    output logic ndac_n_i,
    output logic got_o,
    output logic [7:0] got_byte_o,
    output logic hang_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] h_dio = 8'h00;
    logic h_atn = 1'b0, h_dav = 1'b0, h_nrfd = 1'b0, h_ndac = 1'b0;
    // open-collector lines: once every party lets go they rest unasserted
    assign dio_i = h_dio | (dio_oe_o ? dio_o : 8'h00);
    assign atn_n_i = ~h_atn;
    assign eoi_n_i = ~eoi_oe_o;
    assign dav_n_i = ~(h_dav | dav_oe_o);
    assign nrfd_n_i = ~(h_nrfd | nrfd_oe_o);
    assign ndac_n_i = ~(h_ndac | ndac_oe_o);
    // bounded wait on a handshake line; a stuck device flags a hang
    task automatic wait_line(input int s, input logic v);
        for (int n = 0; n < 300; n++) begin
            if ((s == 0 ? nrfd_n_i : s == 1 ? ndac_n_i : dav_n_i) === v) return;
            @(posedge mclk_i);
        end
        hang_o = 1'b1;
    endtask
    // source handshake; commands travel with attention held asserted
    task automatic send_byte(input logic [7:0] b, input logic atn);
        h_nrfd <= 1'b0;
        h_ndac <= 1'b0;
        h_atn <= atn;
        h_dio <= b;
        @(posedge mclk_i);
        wait_line(1, 1'b0);
        wait_line(0, 1'b1);
        @(posedge mclk_i);
        h_dav <= 1'b1;
        @(posedge mclk_i);
        wait_line(1, 1'b1);
        h_dav <= 1'b0;
        h_dio <= 8'h00;
        @(posedge mclk_i);
    endtask
    // acceptor handshake; stays not-ready afterwards so a talker must hold
    task automatic get_byte();
        h_atn <= 1'b0;
        h_ndac <= 1'b1;
        h_nrfd <= 1'b0;
        @(posedge mclk_i);
        wait_line(2, 1'b0);
        got_byte_o <= dio_i;
        got_o <= 1'b1;
        h_nrfd <= 1'b1;
        h_ndac <= 1'b0;
        @(posedge mclk_i);
        got_o <= 1'b0;
        wait_line(2, 1'b1);
        h_ndac <= 1'b1;
    endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the instrument bus talker/listener port
`include "instrument_bus_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ren_n_i = 1'b1, ifc_n_i = 1'b1;
    logic [4:0] addr_i = 5'h00;
    logic [4:0] dev;
    logic [31:0] wdata_i = 32'h00000000;
    logic [31:0] rdata_o;
    logic [7:0] dio_i, dio_o, got_byte, ch;
    logic atn_n_i, eoi_n_i, dav_n_i, nrfd_n_i, ndac_n_i, dio_oe_o, dav_oe_o, eoi_oe_o, nrfd_oe_o, ndac_oe_o;
    logic srq_oe_o, remote_o, lockout_o, dev_clear_o, got, hang, rd_q = 1'b0, clr_seen = 1'b0;
    int miscompares = 0, total_checks = 0, cycles = 0;
    integer seed = 32'he07e17ea;
    logic [31:0] exp_q[$];
    logic [7:0] msg[6];
    always #50 mclk_i = ~mclk_i;
    instrument_bus_talker_listener DUT (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .dio_i,
        .atn_n_i, .ren_n_i, .ifc_n_i, .eoi_n_i, .dav_n_i, .nrfd_n_i, .ndac_n_i, .dio_o, .dio_oe_o, .dav_oe_o,
        .eoi_oe_o, .nrfd_oe_o, .ndac_oe_o, .srq_oe_o, .remote_o, .lockout_o, .dev_clear_o);
    host_ctrl_model HOST (.mclk_i, .dio_o, .dio_oe_o, .dav_oe_o, .eoi_oe_o, .nrfd_oe_o, .ndac_oe_o, .dio_i,
        .atn_n_i, .eoi_n_i, .dav_n_i, .nrfd_n_i, .ndac_n_i, .got_o(got), .got_byte_o(got_byte), .hang_o(hang));
    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // the read answer is noted now and judged by the watcher a cycle later
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] b);
        HOST.send_byte(b, 1'b1);
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic clear_by(input logic [7:0] b, input logic e);
        clr_seen = 1'b0;
        cmd(b);
        chk(clr_seen, e);
    endtask
    // watcher: every result that appears retires the oldest note
    always @(posedge mclk_i) begin
        rd_q <= rd_i;
        if (dev_clear_o === 1'b1) clr_seen = 1'b1;
        if (rd_q === 1'b1 || got === 1'b1)
            chk(rd_q === 1'b1 ? rdata_o : {23'h0, eoi_oe_o, got_byte}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
        cycles++;
        if (cycles == 60000 || hang === 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        dev = 5'(1 + $unsigned($random(seed)) % 30);
        rd(`CTRL_OFS, 32'h10c);
        rd(5'h1c, 32'h0);
        wr(`CTRL_OFS, 32'h15f);
        rd(`CTRL_OFS, 32'h14c);
        wr(`CTRL_OFS, {23'h0, 1'b1, 3'h0, dev});
        ren_n_i <= 1'b0;
        cmd(`CMD_LLO);
        chk(remote_o, 1'b1);
        chk(lockout_o, 1'b1);
        cmd({3'h1, dev});
        // chained command and a single trailing query, well under the length cap
        msg = '{8'h41 + 8'($random(seed) & 15), `CHR_SEMI, 8'h51, 8'h3f, `CHR_CR, `CHR_LF};
        foreach (msg[i]) begin
            HOST.send_byte(msg[i], 1'b0);
            rd(`RX_OFS, {21'h0, 1'b1, i == 5, i == 1, msg[i]});
        end
        cmd(`CMD_GTL);
        chk(remote_o, 1'b0);
        clear_by(`CMD_SDC, 1'b1);
        cmd(`CMD_UNL);
        clear_by(`CMD_SDC, 1'b0);
        clear_by(`CMD_DCL, 1'b1);
        clear_by(8'h08, 1'b0);
        // one answer under each terminator choice; nothing leaves before the talk address
        for (int t = 0; t < 4; t++) begin
            ch = 8'h30 + 8'($random(seed) & 63);
            wr(`CTRL_OFS, {23'h0, 1'b1, 1'b0, 2'(t), dev});
            wr(`TX_OFS, {24'h0, ch});
            wr(`TXCMD_OFS, 32'h1);
            repeat (10) @(posedge mclk_i);
            chk(dio_oe_o, 1'b0);
            exp_q.push_back({23'h0, t == 3, ch});
            if (t < 2) exp_q.push_back({24'h0, t == 0 ? `CHR_CR : `CHR_LF});
            if (t < 3) exp_q.push_back({24'h0, t == 1 ? `CHR_CR : `CHR_LF});
            cmd({3'h2, dev});
            repeat (t < 2 ? 3 : 4 - t) HOST.get_byte();
            chk(ndac_oe_o, 1'b0);
            cmd(`CMD_UNT);
        end
        wr(`STB_OFS, 32'h81);
        wr(`SRE_OFS, 32'h81);
        repeat (2) @(posedge mclk_i);
        chk(srq_oe_o, 1'b0);
        wr(`SRE_OFS, 32'hc1);
        repeat (2) @(posedge mclk_i);
        chk(srq_oe_o, 1'b1);
        cmd(`CMD_SPE);
        cmd({3'h2, dev});
        exp_q.push_back(32'hc1);
        HOST.get_byte();
        cmd(`CMD_SPD);
        cmd(`CMD_UNT);
        rd(`STB_OFS, 32'h0);
        chk(srq_oe_o, 1'b0);
        // an answer in flight, so the interface clear has something to cut
        wr(`TX_OFS, {24'h0, ch});
        wr(`TXCMD_OFS, 32'h1);
        cmd({3'h2, dev});
        HOST.h_atn <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk(dio_oe_o, 1'b1);
        ifc_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk(dav_oe_o | dio_oe_o, 1'b0);
        ifc_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        // deselecting the interface must let go of every bus line
        HOST.h_atn <= 1'b1;
        wr(`STB_OFS, 32'h1);
        repeat (2) @(posedge mclk_i);
        chk({srq_oe_o, ndac_oe_o}, 2'b11);
        wr(`CTRL_OFS, {23'h0, 1'b0, 3'h0, dev});
        repeat (2) @(posedge mclk_i);
        chk({srq_oe_o, ndac_oe_o, nrfd_oe_o}, 3'h0);
        chk(exp_q.size(), 0);
        tally_and_finish();
    end
endmodule
